// File: design/cba_arbiter.sv
/*
 * Calibration bus arbiter: shares the internal configuration bus between
 * the calibration engine and the user reconfiguration port, holds the
 * calibration enable and capability registers and drives the busy outputs.
 * Assumes a byte-wide reconfiguration port in the same clock domain, one
 * access per clock, and a reset controller watching the busy outputs.
 *
 */
`timescale 1ns/10ps
`include "cba_params.svh"

module cba_arbiter
    import cba_pkg::*;
#(
    parameter int  CAL_CYCLES = 64,
    parameter bit  IS_PLL     = 1'b0
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Options fixed at build time
    input  wire logic        sep_wait_en,
    input  wire logic        csr_en,
    // Reconfiguration port
    input  wire logic [10:0] reconfig_address,
    input  wire logic        reconfig_read,
    input  wire logic        reconfig_write,
    input  wire logic [7:0]  reconfig_writedata,
    output logic [7:0]       reconfig_readdata,
    output logic             reconfig_waitrequest,
    // Busy outputs
    output logic             tx_cal_busy,
    output logic             rx_cal_busy,
    output logic             pll_cal_busy
);
    cba_owner_t owner_reg;
    cba_owner_t owner_next;
    logic [7:0] calen_reg;
    logic [7:0] calen_next;
    logic [1:0] busy_en_reg;
    logic [1:0] busy_en_next;
    logic [1:0] delay_reg;
    logic [1:0] delay_next;
    logic       stuck_reg;
    logic       stuck_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic eng_running;
    logic eng_finished;
    logic cal_start;
    logic cal_abort;
    logic busy_node;
    logic eng_owns;
    logic wr_arb;
    logic wr_calen;
    logic wr_cap;
    logic rd_ok;
    logic tx_busy_g;
    logic rx_busy_g;

    assign eng_owns = (owner_reg != CBA_USER);
    assign wr_arb   = reconfig_write && (reconfig_address == `CBA_ARB_OFFSET);
    assign wr_calen = reconfig_write && (reconfig_address == `CBA_CALEN_OFFSET);
    assign wr_cap   = reconfig_write && (reconfig_address == `CBA_CHCAP_OFFSET);

    assign cal_abort = wr_arb && eng_running
                       && (reconfig_writedata == `CBA_ARB_ABORT_VAL);
    // Engine starts a run when the bus is handed back with an enable set
    assign cal_start = (owner_reg == CBA_USER) && wr_arb
                       && reconfig_writedata[`CBA_ARB_OWNER_BIT] && (calen_reg != 8'h00);

    cba_cal_engine #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_engine (
        .clock    (clock),
        .rstn     (rstn),
        .start    (cal_start),
        .abort    (cal_abort),
        .run_ok   (1'b1),
        .running  (eng_running),
        .finished (eng_finished)
    );

    // busy tracks the run; delayed and stuck busy
    assign busy_node = eng_running || delay_reg == 2'd0 && stuck_reg;

    // Ownership machine
    always_comb begin
        owner_next = owner_reg;
        // ownership moves only on writes or run end
        unique case (owner_reg)
            CBA_ENGINE_CAL: begin
                if (cal_abort) begin
                    owner_next = CBA_USER;
                end else if (eng_finished) begin
                    owner_next = CBA_ENGINE_IDLE;
                end
            end
            CBA_ENGINE_IDLE: begin
                // request write taken while engine holds the bus between runs
                // bit 0 low requests user control
                if (wr_arb && !reconfig_writedata[`CBA_ARB_OWNER_BIT]) begin
                    owner_next = CBA_USER;
                end
            end
            CBA_USER: begin
                // bit 0 high hands the bus to the engine
                // 0x1 or 0x3 both return the bus
                if (wr_arb && reconfig_writedata[`CBA_ARB_OWNER_BIT]) begin
                    owner_next = (calen_reg != 8'h00) ? CBA_ENGINE_CAL : CBA_ENGINE_IDLE;
                end
            end
            default: owner_next = CBA_ENGINE_IDLE;
        endcase
    end

    // Register writes
    always_comb begin
        calen_next   = calen_reg;
        busy_en_next = busy_en_reg;
        delay_next   = delay_reg;
        stuck_next   = stuck_reg;
        // enable register, user owner only; PLL keeps bits 7:1 zero
        if (wr_calen && !eng_owns) begin
            calen_next = IS_PLL ? {7'h00, reconfig_writedata[0]}
                                : {6'h00, reconfig_writedata[1:0]};
        end
        // Enables are consumed once a run starts
        if (cal_start) begin
            calen_next = 8'h00;
        end
        // busy output enables are soft, always writable
        if (wr_cap) begin
            busy_en_next = {reconfig_writedata[`CBA_CAP_RXEN_BIT],
                            reconfig_writedata[`CBA_CAP_TXEN_BIT]};
        end
        // count down to raising busy after done cleared
        if (delay_reg != 2'd0) begin
            delay_next = delay_reg - 2'd1;
        end
        // done and owner bits cleared by the user owner: busy sticks until a run finishes
        if (wr_arb && !eng_owns && !reconfig_writedata[`CBA_ARB_DONE_BIT]
            && !reconfig_writedata[`CBA_ARB_OWNER_BIT]) begin
            stuck_next = 1'b1;
            // A repeated clear while already stuck must not reload and dip busy
            if (!stuck_reg) begin
                delay_next = 2'(`CBA_BUSY_DELAY - 1);
            end
        end else if (eng_finished) begin
            stuck_next = 1'b0;
        end
    end

    // Read path; capability reads ignore ownership
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_ok) begin
            unique case (reconfig_address)
                `CBA_ARB_OFFSET: begin
                    rdata_next = {6'h00, !busy_node, eng_owns};
                end
                `CBA_CALEN_OFFSET: begin
                    rdata_next = calen_reg;
                end
                `CBA_CHCAP_OFFSET: begin
                    rdata_next = {2'b00, busy_en_reg, 1'b0, eng_owns,
                                  rx_busy_g, tx_busy_g};
                end
                `CBA_PLLCAP_OFFSET: begin
                    rdata_next = {5'h00, eng_owns, pll_cal_busy, 1'b0};
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // offset zero not readable while wait is high
    assign rd_ok = reconfig_read && !(reconfig_waitrequest
                   && reconfig_address == `CBA_ARB_OFFSET);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            // engine owns the bus through power-up calibration
            owner_reg   <= CBA_ENGINE_CAL;
            calen_reg   <= `CBA_CALEN_RESET;
            // busy output enables power up set
            busy_en_reg <= `CBA_CAP_EN_RESET;
            delay_reg   <= 2'd0;
            stuck_reg   <= 1'b0;
            rdata_reg   <= 8'h00;
        end else begin
            owner_reg   <= owner_next;
            calen_reg   <= calen_next;
            busy_en_reg <= busy_en_next;
            delay_reg   <= delay_next;
            stuck_reg   <= stuck_next;
            rdata_reg   <= rdata_next;
        end
    end

    // gate the shared node per direction
    assign tx_busy_g = busy_node && busy_en_reg[0];
    assign rx_busy_g = busy_node && busy_en_reg[1];
    assign tx_cal_busy  = tx_busy_g;
    assign rx_cal_busy  = rx_busy_g;
    assign pll_cal_busy = busy_node;
    assign reconfig_readdata = rdata_reg;

    // wait follows ownership unless separated by options
    assign reconfig_waitrequest = eng_owns && !(sep_wait_en && csr_en);

    // Assertions
    a_wait_owner: assert property (@(posedge clock) disable iff (!rstn)
        !(sep_wait_en && csr_en) |-> (reconfig_waitrequest == eng_owns))
        else $error("wait does not follow ownership");
    a_wait_sep: assert property (@(posedge clock) disable iff (!rstn)
        (sep_wait_en && csr_en) |-> !reconfig_waitrequest)
        else $error("wait raised in separated mode");
    a_grant_user: assert property (@(posedge clock) disable iff (!rstn)
        (owner_reg == CBA_ENGINE_IDLE && wr_arb && !reconfig_writedata[0])
        |=> owner_reg == CBA_USER)
        else $error("user request not granted");
    a_abort_user: assert property (@(posedge clock) disable iff (!rstn)
        cal_abort |=> (owner_reg == CBA_USER) && !eng_running)
        else $error("abort did not return bus");
    a_busy_delay: assert property (@(posedge clock) disable iff (!rstn)
        (wr_arb && !eng_owns && !reconfig_writedata[1] && !reconfig_writedata[0]
         && !eng_running && !stuck_reg) |-> !busy_node ##1 !busy_node ##1 busy_node)
        else $error("busy not raised two clocks after done clear");
    a_tx_mask: assert property (@(posedge clock) disable iff (!rstn)
        !busy_en_reg[0] |-> !tx_cal_busy)
        else $error("tx busy high while disabled");
    a_rx_mask: assert property (@(posedge clock) disable iff (!rstn)
        !busy_en_reg[1] |-> !rx_cal_busy)
        else $error("rx busy high while disabled");
    a_busy_run: assert property (@(posedge clock) disable iff (!rstn)
        eng_running |-> pll_cal_busy)
        else $error("busy dropped during run");
    a_cap_read: assert property (@(posedge clock) disable iff (!rstn)
        (reconfig_read && reconfig_address == `CBA_CHCAP_OFFSET)
        |=> reconfig_readdata[2] == $past(eng_owns))
        else $error("owner bit wrong on capability read");
    a_done_read: assert property (@(posedge clock) disable iff (!rstn)
        (rd_ok && reconfig_address == `CBA_ARB_OFFSET)
        |=> reconfig_readdata[1] == !$past(busy_node))
        else $error("done bit not inverted busy");
    a_pll_owner: assert property (@(posedge clock) disable iff (!rstn)
        (reconfig_read && reconfig_address == `CBA_PLLCAP_OFFSET)
        |=> reconfig_readdata[2] == $past(eng_owns)
            && reconfig_readdata[1] == $past(pll_cal_busy))
        else $error("owner or busy bit wrong on pll capability read");
    a_cap_busy: assert property (@(posedge clock) disable iff (!rstn)
        (reconfig_read && reconfig_address == `CBA_CHCAP_OFFSET)
        |=> reconfig_readdata[1] == $past(rx_cal_busy)
            && reconfig_readdata[0] == $past(tx_cal_busy))
        else $error("busy bits wrong on capability read");
    a_tx_gate: assert property (@(posedge clock) disable iff (!rstn)
        busy_en_reg[0] |-> (tx_cal_busy == pll_cal_busy))
        else $error("enabled tx busy differs from node");
    a_rx_gate: assert property (@(posedge clock) disable iff (!rstn)
        busy_en_reg[1] |-> (rx_cal_busy == pll_cal_busy))
        else $error("enabled rx busy differs from node");
    a_calen_rsvd: assert property (@(posedge clock) disable iff (!rstn)
        (calen_reg[7:2] == 6'h00) && !(IS_PLL && calen_reg[1]))
        else $error("reserved enable bit set");
    a_calen_refuse: assert property (@(posedge clock) disable iff (!rstn)
        (wr_calen && eng_owns) |=> $stable(calen_reg))
        else $error("enable register written while engine owns bus");
    a_owner_hold: assert property (@(posedge clock) disable iff (!rstn)
        (!reconfig_write && !eng_finished) |=> $stable(owner_reg))
        else $error("ownership moved without cause");
    // Reset values use reset itself as the trigger, so no disable here
    a_reset_owner: assert property (@(posedge clock)
        !rstn |=> eng_owns && pll_cal_busy)
        else $error("engine does not own bus after reset");
    a_en_reset: assert property (@(posedge clock)
        !rstn |=> busy_en_reg == 2'h3)
        else $error("busy enables not set after reset");
endmodule // cba_arbiter

// File: design/cba_cal_engine.sv
/*
 * Calibration engine model of the arbiter: sequences one calibration run.
 * A start request with a nonzero enable set runs for a parameter number of
 * clocks; an abort ends the run early. Assumes one clock and sync reset.
 */
`timescale 1ns/10ps
`include "cba_params.svh"

module cba_cal_engine
    import cba_pkg::*;
#(
    parameter int CAL_CYCLES = 64
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Control
    input  wire logic start,
    input  wire logic abort,
    input  wire logic run_ok,
    // Status
    output logic      running,
    output logic      finished
);
    localparam int CW = $clog2(CAL_CYCLES + 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          run_reg;
    logic          run_next;
    logic          fin_reg;
    logic          fin_next;

    // Run counter; starts busy so power-up calibration completes first
    always_comb begin
        count_next = count_reg;
        run_next   = run_reg;
        fin_next   = 1'b0;
        if (abort) begin
            run_next = 1'b0;
        end else if (start && run_ok) begin
            run_next   = 1'b1;
            count_next = CW'(CAL_CYCLES);
        end else if (run_reg) begin
            if (count_reg <= CW'(1)) begin
                run_next = 1'b0;
                fin_next = 1'b1;
            end else begin
                count_next = count_reg - CW'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            count_reg <= CW'(CAL_CYCLES);
            run_reg   <= 1'b1;
            fin_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
            fin_reg   <= fin_next;
        end
    end

    assign running  = run_reg;
    assign finished = fin_reg;

    // Run must end within 1000 clocks of its start
    a_run_ends: assert property (@(posedge clock) disable iff (!rstn)
        $rose(run_reg) |-> ##[1:1000] !run_reg)
        else $error("calibration run did not end");
endmodule // cba_cal_engine

// File: design/cba_params.svh
/*
 * Constants for the calibration bus arbiter: register offsets, field
 * positions, reset values and timing counts. Included by the arbiter, the
 * engine and the testbench; holds definitions only.
 */
`ifndef CBA_PARAMS_SVH
`define CBA_PARAMS_SVH

// Register offsets on the reconfiguration address
`define CBA_ARB_OFFSET      11'h000
`define CBA_CALEN_OFFSET    11'h100
`define CBA_PLLCAP_OFFSET   11'h480
`define CBA_CHCAP_OFFSET    11'h481

// bus_arbitration_ctrl fields
`define CBA_ARB_OWNER_BIT   0
`define CBA_ARB_DONE_BIT    1
`define CBA_ARB_ABORT_VAL   8'h02

// calibration_enable fields
`define CBA_CALEN_RX_BIT    0
`define CBA_CALEN_TX_BIT    1
`define CBA_CALEN_RESET     8'h00

// channel_capability_status fields
`define CBA_CAP_TXBUSY_BIT  0
`define CBA_CAP_RXBUSY_BIT  1
`define CBA_CAP_OWNER_BIT   2
`define CBA_CAP_TXEN_BIT    4
`define CBA_CAP_RXEN_BIT    5
`define CBA_CAP_EN_RESET    2'h3

// Timing: busy rises this many clocks after a write of 0 to the done bit
`define CBA_BUSY_DELAY      2

`endif

// File: design/cba_pkg.sv
/*
 * Types shared by the calibration bus arbiter files.
 * Assumes cba_params.svh is on the include path.
 */
package cba_pkg;
    // Owner of the internal configuration bus
    typedef enum logic [1:0] {
        CBA_ENGINE_IDLE = 2'b00,
        CBA_ENGINE_CAL  = 2'b01,
        CBA_USER        = 2'b10
    } cba_owner_t;
endpackage

// File: dv/cba_user_master.sv
/*
 * User reconfiguration master model: single-cycle read and write strobes.
 * Assumes the arbiter samples on the rising edge and never stalls a write.
 */
`timescale 1ns/10ps

module cba_user_master (
    // Clock
    input  wire logic       clock,
    // Reconfiguration port
    output logic [10:0]     address,
    output logic            read,
    output logic            write,
    output logic [7:0]      writedata,
    input  wire logic [7:0] readdata
);
    // Idle bus from time zero
    initial begin
        address   = 11'h000;
        read      = 1'b0;
        write     = 1'b0;
        writedata = 8'h00;
    end

    // One write; the idle gap keeps a strobe from being set twice in a step
    task automatic wr(input logic [10:0] a, input logic [7:0] v);
        @(negedge clock);
        address   = a;
        writedata = v;
        write     = 1'b1;
        @(negedge clock);
        write     = 1'b0;
        writedata = ~v; // Released data never repeats the last value
    endtask

    // One read; data is registered on the sampling edge
    task automatic rd(input logic [10:0] a, output logic [7:0] v);
        @(negedge clock);
        address = a;
        read    = 1'b1;
        @(negedge clock);
        read    = 1'b0;
        v       = readdata;
    endtask
endmodule // cba_user_master

// File: dv/tb_cba_arbiter.sv
/*
 * Testbench for the calibration bus arbiter: drives the reconfiguration
 * port through the master model, checks busy, wait and register values.
 * Assumes a shortened run length so every calibration lasts a few cycles.
 */
`timescale 1ns/10ps
`include "cba_params.svh"

module tb_cba_arbiter;
    localparam int         CYC     = 8;
    localparam logic [7:0] MSK [3] = '{8'h10, 8'h20, 8'h00};
    localparam logic [7:0] CAL [3] = '{8'h02, 8'h01, 8'h01};
    localparam logic [7:0] STS [3] = '{8'h0d, 8'h0b, 8'h09};
    localparam logic [7:0] CAP [3] = '{8'h15, 8'h26, 8'h04};

    logic        clock;
    logic        rstn;
    logic        sep_wait_en;
    logic        csr_en;
    logic [10:0] address;
    logic        read;
    logic        write;
    logic [7:0]  writedata;
    logic [7:0]  readdata;
    logic        waitreq;
    logic        tx_busy;
    logic        rx_busy;
    logic        pll_busy;
    logic [7:0]  stat;
    logic [7:0]  d;
    int          n;
    int          bad_count;
    int          cmp_count;

    // Wait and busy levels packed for one compare
    assign stat = {4'h0, waitreq, tx_busy, rx_busy, pll_busy};

    cba_arbiter #(.CAL_CYCLES(CYC), .IS_PLL(1'b0)) DUT (
        .clock(clock), .rstn(rstn), .sep_wait_en(sep_wait_en), .csr_en(csr_en),
        .reconfig_address(address), .reconfig_read(read), .reconfig_write(write),
        .reconfig_writedata(writedata), .reconfig_readdata(readdata),
        .reconfig_waitrequest(waitreq), .tx_cal_busy(tx_busy),
        .rx_cal_busy(rx_busy), .pll_cal_busy(pll_busy));

    cba_user_master u_master (
        .clock(clock), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata));

    // Clock at 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Bounded wait for the end of a run
    task automatic wait_idle();
        int k;
        k = 0;
        while (pll_busy !== 1'b0 && k < 60) begin
            @(negedge clock);
            k++;
        end
        check(stat, 8'h08, "engine idle");
    endtask

    // Counts busy cycles; each must show the expected levels
    task automatic run(input logic [7:0] exp, output int cnt);
        cnt = 0;
        // First busy cycle already shows when the return write ends
        while (pll_busy === 1'b1 && cnt < 100) begin
            check(stat, exp, "busy during run");
            cnt++;
            @(negedge clock);
        end
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        bad_count   = 0;
        cmp_count   = 0;
        rstn        = 1'b0;
        sep_wait_en = 1'b0;
        csr_en      = 1'b0;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        check(stat, 8'h0f, "power-up levels");
        u_master.rd(`CBA_CHCAP_OFFSET, d);
        check(d, 8'h37, "channel status");
        u_master.rd(`CBA_PLLCAP_OFFSET, d);
        check(d, 8'h06, "pll status");
        u_master.rd(`CBA_ARB_OFFSET, d);
        check(d, 8'h06, "blocked read");
        u_master.rd(11'h200, d);
        check(d, 8'h00, "unmapped read");
        wait_idle();
        $display("Test power-up done");

        // Grant, then a full run with both outputs enabled
        u_master.wr(`CBA_ARB_OFFSET, 8'h00);
        check(stat, 8'h00, "granted");
        u_master.rd(`CBA_ARB_OFFSET, d);
        check(d, 8'h02, "done bit");
        u_master.rd(`CBA_CALEN_OFFSET, d);
        u_master.wr(`CBA_CALEN_OFFSET, d | 8'h01);
        u_master.wr(`CBA_ARB_OFFSET, 8'h01);
        run(8'h0f, n);
        check(8'(n), 8'(CYC), "run length");
        wait_idle();
        u_master.wr(`CBA_CALEN_OFFSET, 8'h02);
        u_master.wr(`CBA_ARB_OFFSET, 8'h00);
        u_master.rd(`CBA_CALEN_OFFSET, d);
        check(d, 8'h00, "enable write refused");
        $display("Test full run done");

        // Masked runs; the first two are aborted
        for (int i = 0; i < 3; i++) begin // one duplex channel, masking allowed
            u_master.wr(`CBA_CHCAP_OFFSET, MSK[i]);
            u_master.wr(`CBA_CALEN_OFFSET, CAL[i]);
            u_master.wr(`CBA_ARB_OFFSET, 8'h01);
            @(negedge clock);
            check(stat, STS[i], "masked busy");
            u_master.rd(`CBA_CHCAP_OFFSET, d);
            check(d, CAP[i], "masked status");
            if (i < 2) begin
                u_master.wr(`CBA_ARB_OFFSET, 8'h02);
                check(stat, 8'h00, "aborted");
            end else begin
                wait_idle();
                u_master.wr(`CBA_ARB_OFFSET, 8'h00);
            end
        end
        $display("Test masking done");

        // Return with no enable set: bus goes back, nothing runs
        u_master.wr(`CBA_CHCAP_OFFSET, 8'h30);
        u_master.wr(`CBA_ARB_OFFSET, 8'h03);
        repeat (3) @(negedge clock);
        check(stat, 8'h08, "returned idle");
        u_master.wr(`CBA_ARB_OFFSET, 8'h00);
        check(stat, 8'h00, "regained");
        $display("Test plain return done");

        // Clearing done as owner: busy two clocks later, then stuck
        u_master.wr(`CBA_ARB_OFFSET, 8'h00);
        check(stat, 8'h00, "busy not yet");
        @(negedge clock);
        check(stat, 8'h07, "busy raised");
        repeat (20) @(negedge clock);
        check(stat, 8'h07, "busy stuck");
        u_master.rd(`CBA_ARB_OFFSET, d);
        check(d, 8'h00, "done reads low");
        $display("Test done clear done");

        // Second reset with wait separated from ownership
        rstn        = 1'b0;
        sep_wait_en = 1'b1;
        csr_en      = 1'b1;
        repeat (6) @(negedge clock);
        rstn = 1'b1;
        check(stat, 8'h07, "separated wait");
        u_master.rd(`CBA_CHCAP_OFFSET, d);
        check(d, 8'h37, "owner bit");
        $display("Test separated wait done");
        print_verdict();
    end
endmodule // tb_cba_arbiter
